//--- logic/vdram_host.sv
// Contract
// - No serial clock pulse while row strobe is low in plain write transfers.
// - Split write keeps serial pin direction; pseudo transfer first if output.
// - Pseudo transfer precedes split write of buffer data loaded by a read.
// - Split write row MSB equals the MSB of the originating read transfer.
// - Every one of 512 rows refreshed at least once per 8 ms.
// - Row-only refresh: row address given, column strobe high, transfer high.
// - Split write: column high, transfer low, write low, select high.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Serial word buffer
module stream_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // stream_fifo

// ============================================================
// Video DRAM controller
module vdram_host #(
  parameter int FIFO_DEPTH = vdram_host_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transfer command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire vdram_host_pkg::cmd_t cmd,
  // Serial write stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire vdram_host_pkg::serial_word_t wr_word,
  // Serial read stream
  input wire logic rd_enable,
  input wire logic rd_float,
  output logic rd_valid,
  output logic [vdram_host_pkg::SDATA_W-1:0] rd_data,
  // Status
  output logic port_is_output,
  output logic [vdram_host_pkg::ADDR_W-1:0] serial_pointer,
  // Memory pins
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic transfer_output_enable,
  output logic special_function_select,
  output logic [vdram_host_pkg::ADDR_W-1:0] addr,
  output logic serial_shift_clock,
  output logic serial_enable_low,
  input wire logic [vdram_host_pkg::SDATA_W-1:0] sdata_in,
  output logic [vdram_host_pkg::SDATA_W-1:0] sdata_out,
  output logic sdata_oe
);
  typedef enum logic [2:0] {
    st_idle, st_setup, st_row, st_col, st_xfer_up, st_precharge
  } state_t;

  state_t state;
  vdram_host_pkg::cmd_t cur;
  logic chain_split;
  logic [vdram_host_pkg::TIMER_W-1:0] timer;
  logic [vdram_host_pkg::TIMER_W-1:0] ref_timer;
  logic refresh_due;
  logic buffer_from_read;
  logic read_row_msb;
  logic row_msb_locked;
  logic take_cmd;
  logic take_refresh;
  logic cycle_blocks_serial;
  logic [1:0] ser_phase;
  logic ser_masked;
  logic fifo_valid;
  logic fifo_pop;
  vdram_host_pkg::serial_word_t fifo_word;

  function automatic logic [vdram_host_pkg::TIMER_W-1:0] cycles(input int n);
    cycles = vdram_host_pkg::TIMER_W'(n - 1);
  endfunction

  function automatic logic is_xfer(input vdram_host_pkg::op_t op);
    is_xfer = op inside {vdram_host_pkg::op_read_xfer,
      vdram_host_pkg::op_pseudo_xfer, vdram_host_pkg::op_write_xfer,
      vdram_host_pkg::op_split_write};
  endfunction

  // ==========================================================
  // Serial data buffer
  stream_fifo #(
    .WIDTH($bits(vdram_host_pkg::serial_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  // ==========================================================
  // Refresh interval timer
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_timer <= '0;
      refresh_due <= 1'b0;
    end else begin
      if (ref_timer == cycles(vdram_host_pkg::REF_INTERVAL_CYCLES)) begin
        ref_timer <= '0;
        refresh_due <= 1'b1;
      end else begin
        ref_timer <= ref_timer + 1'b1;
        if (take_refresh) begin
          refresh_due <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Row strobe cycle sequencer
  assign take_refresh = state == st_idle && refresh_due;
  assign take_cmd = state == st_idle && !refresh_due && cmd_valid;
  assign cmd_ready = state == st_idle && !refresh_due;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_idle;
      cur <= '0;
      chain_split <= 1'b0;
      timer <= '0;
    end else begin
      unique case (state)
        st_idle: begin
          if (take_refresh) begin
            cur.op <= vdram_host_pkg::op_counter_refresh;
            state <= st_setup;
            timer <= cycles(vdram_host_pkg::CSR_CYCLES);
          end else if (take_cmd) begin
            cur <= cmd;
            chain_split <= 1'b0;
            if (cmd.op == vdram_host_pkg::op_split_write &&
                (port_is_output || buffer_from_read)) begin
              cur.op <= vdram_host_pkg::op_pseudo_xfer;
              chain_split <= 1'b1;
            end
            state <= st_setup;
            timer <= cycles(vdram_host_pkg::CSR_CYCLES);
          end
        end
        st_setup: begin
          if (timer == '0) begin
            state <= st_row;
            timer <= cycles(vdram_host_pkg::RCD_CYCLES);
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_row: begin
          if (timer == '0) begin
            state <= st_col;
            timer <= cycles(vdram_host_pkg::RAS_CYCLES -
              vdram_host_pkg::RCD_CYCLES);
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_col: begin
          if (timer == '0) begin
            state <= st_xfer_up;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_xfer_up: begin
          state <= st_precharge;
          timer <= cycles(vdram_host_pkg::RP_CYCLES);
        end
        st_precharge: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (chain_split) begin
            cur.op <= vdram_host_pkg::op_split_write;
            chain_split <= 1'b0;
            state <= st_setup;
            timer <= cycles(vdram_host_pkg::CSR_CYCLES);
          end else begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Serial port mode tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      port_is_output <= vdram_host_pkg::PORT_OUT_RESET;
      buffer_from_read <= 1'b0;
      read_row_msb <= 1'b0;
      row_msb_locked <= 1'b0;
    end else if (state == st_xfer_up) begin
      unique case (cur.op)
        vdram_host_pkg::op_read_xfer: begin
          port_is_output <= 1'b1;
          buffer_from_read <= 1'b1;
          read_row_msb <= cur.row[vdram_host_pkg::ADDR_W-1];
          row_msb_locked <= 1'b1;
        end
        vdram_host_pkg::op_pseudo_xfer: begin
          port_is_output <= 1'b0;
          buffer_from_read <= 1'b0;
        end
        vdram_host_pkg::op_write_xfer: begin
          port_is_output <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Memory strobes and address
  always_comb begin
    ras_n = !(state inside {st_row, st_col, st_xfer_up});
    cas_n = 1'b1;
    if (cur.op == vdram_host_pkg::op_counter_refresh) begin
      cas_n = !(state inside {st_setup, st_row, st_col});
    end else if (cur.op != vdram_host_pkg::op_row_refresh) begin
      cas_n = state != st_col;
    end
    transfer_output_enable = !(is_xfer(cur.op) &&
      state inside {st_setup, st_row, st_col});
    we_n = !(state inside {st_setup, st_row} &&
      cur.op inside {vdram_host_pkg::op_pseudo_xfer,
      vdram_host_pkg::op_write_xfer, vdram_host_pkg::op_split_write});
    special_function_select = state inside {st_setup, st_row} &&
      cur.op == vdram_host_pkg::op_split_write;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr <= '0;
    end else if (state == st_idle || state == st_setup) begin
      addr <= cur.row;
      if (cur.op == vdram_host_pkg::op_split_write && row_msb_locked) begin
        addr[vdram_host_pkg::ADDR_W-1] <= read_row_msb;
      end
    end else if (state == st_row) begin
      addr <= cur.col;
    end
  end

  // ==========================================================
  // Serial clock engine
  // A command taken on this edge also holds off a new serial word.
  assign cycle_blocks_serial = take_cmd || (state != st_idle &&
    is_xfer(cur.op) &&
    cur.op != vdram_host_pkg::op_split_write);
  assign fifo_pop = ser_phase == 2'h0 && !cycle_blocks_serial &&
    !port_is_output && fifo_valid;

  always_ff @(posedge clk) begin
    if (reset) begin
      ser_phase <= 2'h0;
      ser_masked <= 1'b0;
      sdata_out <= '0;
      serial_shift_clock <= 1'b0;
      serial_pointer <= vdram_host_pkg::BUF_FIRST;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      unique case (ser_phase)
        2'h0: begin
          if (fifo_pop) begin
            sdata_out <= fifo_word.data;
            ser_masked <= fifo_word.mask;
            ser_phase <= 2'h1;
          end else if (!cycle_blocks_serial && port_is_output &&
                       rd_enable) begin
            ser_masked <= rd_float;
            ser_phase <= 2'h1;
          end
        end
        2'h1: begin
          serial_shift_clock <= 1'b1;
          if (serial_pointer == vdram_host_pkg::BUF_LAST) begin
            serial_pointer <= vdram_host_pkg::BUF_FIRST;
          end else begin
            serial_pointer <= serial_pointer + 1'b1;
          end
          ser_phase <= 2'h2;
        end
        2'h2: begin
          ser_phase <= 2'h3;
        end
        2'h3: begin
          serial_shift_clock <= 1'b0;
          if (port_is_output && !ser_masked) begin
            rd_valid <= 1'b1;
            rd_data <= sdata_in;
          end
          ser_phase <= 2'h0;
        end
      endcase
      if (state == st_xfer_up && is_xfer(cur.op) &&
          cur.op != vdram_host_pkg::op_split_write) begin
        serial_pointer <= cur.col;
      end
    end
  end

  // ==========================================================
  // Serial enable and pin direction
  always_comb begin
    if (state != st_idle && cur.op == vdram_host_pkg::op_pseudo_xfer) begin
      serial_enable_low = 1'b1;
    end else if (state != st_idle &&
                 cur.op == vdram_host_pkg::op_write_xfer) begin
      serial_enable_low = 1'b0;
    end else begin
      serial_enable_low = ser_phase != 2'h0 && ser_masked;
    end
    sdata_oe = !port_is_output;
  end
endmodule // vdram_host

`default_nettype wire

//--- logic/vdram_host_pkg.sv
package vdram_host_pkg;

  // ==========================================================
  // Timing figures and derived cycle counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RAS_NS = 100;
  localparam int T_RCD_NS = 20;
  localparam int T_RP_NS = 70;
  localparam int T_CSR_NS = 10;
  localparam int T_REF_MS = 8;
  localparam int REF_ROWS = 512;
  localparam int RAS_CYCLES = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYCLES = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYCLES = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSR_CYCLES = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INTERVAL_CYCLES =
    (T_REF_MS * 1000000 / CLK_PERIOD_NS) / REF_ROWS;
  localparam int TIMER_W = 12;

  // ==========================================================
  // Geometry and reset values
  localparam int ADDR_W = 9;
  localparam int SDATA_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [8:0] BUF_LAST = 9'h1FF;
  localparam logic [8:0] BUF_FIRST = 9'h000;
  localparam logic PORT_OUT_RESET = 1'b1;

  // ==========================================================
  // Commands and carriers
  typedef enum logic [2:0] {
    op_read_xfer,
    op_pseudo_xfer,
    op_write_xfer,
    op_split_write,
    op_row_refresh,
    op_counter_refresh
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
  } cmd_t;

  typedef struct packed {
    logic mask;
    logic [SDATA_W-1:0] data;
  } serial_word_t;

endpackage

//--- sim/vdram_device_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Video memory serial port model
module vdram_device_model (
  // Strobes and address
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic transfer_output_enable,
  input wire logic special_function_select,
  input wire logic [8:0] addr,
  // Serial port
  input wire logic serial_shift_clock,
  input wire logic serial_enable_low,
  input wire logic [3:0] sdata_out,
  input wire logic sdata_oe,
  output logic [3:0] sdata_in
);
  logic [3:0] buffer [512];
  logic [3:0] dout = 4'h0;
  logic out_mode = 1'b1;
  int ptr = 0, kind = 0, row = 0, viol = 0;
  int cnt [7] = '{default: 0};
  always @(negedge ras_n) begin
    row = addr;
    if (!cas_n) kind = 5;
    else if (transfer_output_enable) kind = 4;
    else if (special_function_select) kind = we_n ? 6 : 3;
    else if (we_n) kind = 0;
    else kind = serial_enable_low ? 1 : 2;
    if (kind < 3) out_mode = (kind == 0);
    cnt[kind]++;
  end
  always @(negedge cas_n) if (!ras_n && kind < 3) ptr = addr;
  always @(posedge transfer_output_enable) begin
    if (!ras_n && kind == 0) begin
      for (int i = 0; i < 512; i++) buffer[i] = 4'(row + i);
    end
  end
  always @(posedge serial_shift_clock) begin
    if (!ras_n && kind inside {1, 2}) viol++;
    if (out_mode == sdata_oe) viol++;
    if (out_mode && !serial_enable_low) dout <= #15 buffer[ptr];
    if (!out_mode && !serial_enable_low) buffer[ptr] = sdata_out;
    ptr = (ptr + 1) % 512;
  end
  assign sdata_in = (out_mode && !serial_enable_low) ? dout : ~dout;
endmodule // vdram_device_model
`default_nettype wire

//--- sim/vdram_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pin protocol checker
module vdram_host_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Memory pins and status
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic transfer_output_enable,
  input wire logic special_function_select,
  input wire logic [vdram_host_pkg::ADDR_W-1:0] addr,
  input wire logic serial_shift_clock,
  input wire logic port_is_output
);
  localparam int REF_MAX = 1600;
  logic ras_q, need_pseudo, seen_rd, rd_msb;
  logic [11:0] ref_gap;
  wire logic fall = ras_q & ~ras_n;
  wire logic xfer = fall & cas_n & ~transfer_output_enable;
  wire logic spl = xfer & special_function_select;
  always_ff @(posedge clk) begin
    ras_q <= reset | ras_n;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      need_pseudo <= 1'b0;
      seen_rd <= 1'b0;
    end else if (xfer && !special_function_select) begin
      need_pseudo <= we_n;
      seen_rd <= seen_rd | we_n;
    end
  end
  always_ff @(posedge clk) begin
    if (xfer && we_n && !special_function_select) begin
      rd_msb <= addr[vdram_host_pkg::ADDR_W-1];
    end
  end
  always_ff @(posedge clk) begin
    if (reset || (fall && !cas_n)) ref_gap <= 12'h000;
    else ref_gap <= ref_gap + 12'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence cas_first;
    $fell(cas_n) && ras_n;
  endsequence
  sequence ras_follows;
    transfer_output_enable ##[1:2] $fell(ras_n);
  endsequence
  a_cas_first: assert property (cas_first |-> ras_follows)
    else $error("counter refresh order broken");
  a_no_sclk: assert property (xfer && !special_function_select |->
    (!$rose(serial_shift_clock)) [*8]) else $error("clock in transfer");
  a_split_input: assert property (spl |-> !port_is_output)
    else $error("split write with port output");
  a_pseudo_first: assert property (spl |-> !need_pseudo)
    else $error("split write without pseudo");
  a_split_msb: assert property (spl && seen_rd |->
    addr[vdram_host_pkg::ADDR_W-1] == rd_msb) else $error("row msb");
  a_split_code: assert property (fall && special_function_select |->
    cas_n && !transfer_output_enable && !we_n) else $error("split code");
  a_row_only: assert property (fall && cas_n && transfer_output_enable |->
    cas_n [*8]) else $error("column strobe in row refresh");
  a_refresh_gap: assert property (ref_gap < REF_MAX)
    else $error("refresh late");
endmodule // vdram_host_asserts
bind vdram_host vdram_host_asserts vdram_host_asserts_inst (
  .clk(clk), .reset(reset), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .transfer_output_enable(transfer_output_enable),
  .special_function_select(special_function_select), .addr(addr),
  .serial_shift_clock(serial_shift_clock), .port_is_output(port_is_output));
`default_nettype wire

//--- sim/vdram_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the video memory controller
module vdram_host_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic rd_enable = 1'b0;
  logic rd_float = 1'b0;
  vdram_host_pkg::cmd_t cmd = '0;
  vdram_host_pkg::serial_word_t wr_word = '0;
  logic cmd_ready, wr_ready, rd_valid, port_is_output, ras_n, cas_n, we_n;
  logic xoe, fsel, sclk, ser_en_n, sdata_oe;
  logic [8:0] addr, ptr_out;
  logic [3:0] rd_data, sdata_in, sdata_out;
  int error_cnt = 0, n_tests = 0, sclk_cnt = 0, i, k, k2, n, c0;
  logic [3:0] got_q [$];
  logic [4:0] wq [$];
  int bufm [512];
  always #5 clk = ~clk;
  vdram_host #(.FIFO_DEPTH(32)) vdram_host_inst (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .rd_enable(rd_enable), .rd_float(rd_float), .rd_valid(rd_valid),
    .rd_data(rd_data), .port_is_output(port_is_output),
    .serial_pointer(ptr_out), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .transfer_output_enable(xoe), .special_function_select(fsel),
    .addr(addr), .serial_shift_clock(sclk), .serial_enable_low(ser_en_n),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe));
  vdram_device_model vdram_device_model_inst (.ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .transfer_output_enable(xoe), .special_function_select(fsel),
    .addr(addr), .serial_shift_clock(sclk), .serial_enable_low(ser_en_n),
    .sdata_out(sdata_out), .sdata_oe(sdata_oe), .sdata_in(sdata_in));
  always @(posedge clk) if (rd_valid === 1'b1) got_q.push_back(rd_data);
  always @(posedge sclk) sclk_cnt++;
  // ========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(input bit idle, input int target);
    int t;
    t = 0;
    while ((idle ? cmd_ready !== 1'b1 : sclk_cnt < target) && t < 4000) begin
      tick(1);
      t++;
    end
    if (t == 4000) begin
      error_cnt++;
      test_done;
    end
  endtask
  task automatic send(input int op, input int r, input int c);
    wait_for(1'b1, 0);
    cmd_valid = 1'b1;
    cmd.op = vdram_host_pkg::op_t'(op);
    cmd.row = 9'(r);
    cmd.col = 9'(c);
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
    wait_for(1'b1, 0);
  endtask
  // ========================================================
  // Main sequence
  initial begin
    void'($urandom(37));
    tick(10);
    reset = 1'b0;
    tick(1);
    check(port_is_output, 1);
    check(ptr_out, 0);
    $display("test reset ended");
    send(0, 421, 509);
    k = sclk_cnt;
    rd_enable = 1'b1;
    wait_for(1'b0, k + 6);
    rd_enable = 1'b0;
    tick(12);
    n = got_q.size();
    k2 = sclk_cnt;
    check(n, k2 - k);
    rd_float = 1'b1;
    rd_enable = 1'b1;
    wait_for(1'b0, k2 + 5);
    rd_enable = 1'b0;
    rd_float = 1'b0;
    tick(12);
    check(got_q.size(), n);
    check(ptr_out, (509 + sclk_cnt - k) % 512);
    check(vdram_device_model_inst.ptr, (509 + sclk_cnt - k) % 512);
    foreach (got_q[j]) check(got_q[j], (930 + j) % 16);
    $display("test serial read ended");
    wr_valid = 1'b1;
    for (i = 0; i < 40 && wr_ready === 1'b1; i++) begin
      wr_word = vdram_host_pkg::serial_word_t'(5'($urandom));
      wq.push_back(wr_word);
      tick(1);
    end
    wr_valid = 1'b0;
    check(i, 32);
    for (i = 0; i < 512; i++) bufm[i] = (421 + i) % 16;
    foreach (wq[j]) if (!wq[j][4]) bufm[(500 + j) % 512] = wq[j][3:0];
    k = sclk_cnt;
    c0 = vdram_device_model_inst.cnt[1];
    send(3, 0, 500);
    check(vdram_device_model_inst.cnt[1], c0 + 1);
    check(vdram_device_model_inst.row / 256, 1);
    wait_for(1'b0, k + 32);
    tick(8);
    check(port_is_output, 0);
    for (i = 0; i < 512; i++) begin
      check(vdram_device_model_inst.buffer[i], bufm[i]);
    end
    $display("test split write ended");
    for (i = 0; i < 6; i++) begin
      c0 = vdram_device_model_inst.cnt[i];
      send(i, $urandom % 256, $urandom % 512);
      check(vdram_device_model_inst.cnt[i] > c0, 1);
    end
    $display("test command codes ended");
    c0 = vdram_device_model_inst.cnt[5];
    tick(1700);
    check(vdram_device_model_inst.cnt[5] > c0, 1);
    check(vdram_device_model_inst.viol, 0);
    $display("test refresh ended");
    test_done;
  end
endmodule // vdram_host_tb_top
`default_nettype wire
